// file: core/eid_map.svh
// register-free constants for the extended decode block
`ifndef EID_MAP_SVH
`define EID_MAP_SVH
`define EID_OFFSET_MAX 8'h5f
`define EID_PTR_RESET 12'h000
`define EID_ACC_RESET 8'h00
`define EID_BANK_RESET 4'h0
`define EID_ACCESS_HI 12'hf00
`define EID_ACCESS_SPLIT 8'h60
`define EID_PTR_TWO 2'h2
`define EID_PTR_RET 2'h3
`define EID_OP_PTRADD 8'he8
`define EID_OP_PTRSUB 8'he9
`define EID_OP_PUSH_LITERAL_OP 8'hea
`define EID_OP_MOVE 8'heb
`define EID_OP_CALL_VIA_ACCUMULATOR_OP 16'h0014
`define EID_OP_ACCUMULATE_TO_FILE_OP 6'h09
`define EID_OP_SECOND 4'hf
`define EID_PC_STEP 21'h000002
`endif

// file: core/eid_pkg.sv
// types of the extended decode block
package eid_pkg;
  typedef enum logic [1:0] {
    EID_ST_RUN = 2'b00,
    EID_ST_NOP = 2'b01,
    EID_ST_MOVE2 = 2'b10
  } eid_state_t;
  typedef struct packed {
    logic req;
    logic we;
    logic [11:0] addr;
    logic [7:0] wdata;
  } eid_mem_t;
  typedef struct packed {
    logic push;
    logic pop;
    logic [20:0] data;
  } eid_stack_t;
endpackage

// file: core/eid_addr_gen.sv
// address formation for file-register arguments
`timescale 1ns/10ps
`include "eid_map.svh"
module eid_addr_gen
  import eid_pkg::*;
(
  input wire logic ext_en_in,
  input wire logic access_in,
  input wire logic [7:0] file_in,
  input wire logic [3:0] bank_in,
  input wire logic [11:0] ptr_two_in,
  output logic indexed_out,
  output logic [11:0] addr_out
);
  wire logic small_arg;
  wire logic [11:0] access_addr;
  wire logic [11:0] bank_addr;
  wire logic [11:0] index_addr;
  assign small_arg = file_in <= `EID_OFFSET_MAX;
  assign indexed_out = ext_en_in & ~access_in & small_arg;
  // access arguments below 60h map to ram, 60h and up to the special registers
  assign access_addr = (file_in < `EID_ACCESS_SPLIT) ?
    {4'h0, file_in} : (`EID_ACCESS_HI | {4'h0, file_in});
  assign bank_addr = {bank_in, file_in};
  // pointer two at zero gives the plain access location back
  assign index_addr = ptr_two_in + {4'h0, file_in};
  assign addr_out = indexed_out ? index_addr :
    (access_in ? bank_addr : access_addr);
endmodule // eid_addr_gen

// file: core/eid_decode.sv
// extended instruction decode and execute core slice
`timescale 1ns/10ps
`include "eid_map.svh"
// Behaviour
// - extended opcodes and indexed addressing stay off while config bit clear
// - config bit enables both new opcodes and indexed interpretation
// - disabled: access bit 0 uses access bank, 1 uses bank register
// - enabled, access 0, argument up to 5Fh: pointer two plus offset
// - larger argument or access bit 1 keeps literal addressing
// - pointer two at zero maps offsets onto original access locations
// - indexed form is recognised only from cleared access bit
// - destination bit 0 writes accumulator, 1 writes data register
// - indexed add accumulator to file, one cycle, destination selects
// - subtract-return: subtract from pointer two then pop top of stack
// - subtract-return takes two cycles, second one a no-operation
// - return forms act on pointer two only, field 3 never elsewhere
// - pointer subtract: 6-bit literal from pointer 0..2, one cycle
// - push literal stores at pointer two then decrements it, one cycle
// - call via accumulator: push next address, pc from latches, two cycles
module eid_decode
  import eid_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic extended_set_config_bit_in,
  input wire logic insn_valid_in,
  input wire logic [15:0] insn_in,
  input wire logic [20:0] pc_in,
  input wire logic [7:0] mem_rdata_in,
  input wire logic [20:0] top_of_return_stack_in,
  input wire logic [7:0] program_counter_high_latch_in,
  input wire logic [7:0] program_counter_upper_latch_in,
  input wire logic [3:0] bank_select_register_in,
  output eid_mem_t mem_out,
  output eid_stack_t stack_out,
  output logic pc_load_out,
  output logic [20:0] pc_value_out,
  output logic busy_out,
  output logic flags_we_out,
  output logic [7:0] accumulator_register_out,
  output logic [11:0] indirect_pointer_zero_out,
  output logic [11:0] indirect_pointer_one_out,
  output logic [11:0] indirect_pointer_two_out
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  eid_state_t state_q, state_d;
  logic [11:0] ptr_q [0:2];
  logic [11:0] ptr_d [0:2];
  logic [7:0] acc_q, acc_d;
  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire logic en;
  wire logic run;
  wire logic [1:0] fld;
  wire logic [5:0] lit6;
  wire logic [7:0] lit8;
  wire logic is_ptradd;
  wire logic is_ptrsub;
  wire logic is_ret;
  wire logic is_push_literal_op;
  wire logic is_move1;
  wire logic is_call_via_accumulator_op;
  wire logic is_accumulate_to_file_op;
  wire logic move_second;
  wire logic ax_indexed;
  wire logic [11:0] ax_addr;
  wire logic [8:0] sum;
  wire logic [11:0] mv_src_addr;
  wire logic [11:0] mv_dst_addr;
  assign en = extended_set_config_bit_in;
  assign run = insn_valid_in & (state_q == EID_ST_RUN);
  assign fld = insn_in[7:6];
  assign lit6 = insn_in[5:0];
  assign lit8 = insn_in[7:0];
  assign is_ptradd = en & run & (insn_in[15:8] == `EID_OP_PTRADD);
  assign is_ptrsub = en & run & (insn_in[15:8] == `EID_OP_PTRSUB);
  assign is_ret = fld == `EID_PTR_RET;
  assign is_push_literal_op = en & run & (insn_in[15:8] == `EID_OP_PUSH_LITERAL_OP);
  assign is_move1 = en & run & (insn_in[15:8] == `EID_OP_MOVE) &
    insn_in[7];
  assign is_call_via_accumulator_op = en & run & (insn_in == `EID_OP_CALL_VIA_ACCUMULATOR_OP);
  assign is_accumulate_to_file_op = run & (insn_in[15:10] == `EID_OP_ACCUMULATE_TO_FILE_OP);
  assign move_second = insn_valid_in & (state_q == EID_ST_MOVE2) &
    (insn_in[15:12] == `EID_OP_SECOND);
  assign sum = {1'b0, acc_q} + {1'b0, mem_rdata_in};
  // source offset is read in the first word, memory answers combinationally
  assign mv_src_addr = ptr_q[2] + {5'h00, insn_in[6:0]};
  assign mv_dst_addr = ptr_q[2] + {5'h00, insn_in[6:0]};
  eid_addr_gen u_addr (
    .ext_en_in(en),
    .access_in(insn_in[8]),
    .file_in(insn_in[7:0]),
    .bank_in(bank_select_register_in),
    .ptr_two_in(ptr_q[2]),
    .indexed_out(ax_indexed),
    .addr_out(ax_addr)
  );
  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  function automatic logic [11:0] ptr_step(input logic [11:0] p,
    input logic [5:0] k, input logic add);
    ptr_step = add ? p + {6'h00, k} : p - {6'h00, k};
  endfunction
  logic [7:0] mv_data_q;
  always_comb begin
    state_d = state_q;
    acc_d = acc_q;
    for (int i = 0; i < 3; i++) begin
      ptr_d[i] = ptr_q[i];
    end
    mem_out = '0;
    stack_out = '0;
    pc_load_out = 1'b0;
    pc_value_out = '0;
    flags_we_out = 1'b0;
    case (state_q)
      EID_ST_RUN: begin
        if (is_ptradd | is_ptrsub) begin
          // no status flag update for pointer arithmetic
          if (is_ret) begin
            ptr_d[2] = ptr_step(ptr_q[2], lit6, is_ptradd);
            stack_out.pop = 1'b1;
            pc_load_out = 1'b1;
            pc_value_out = top_of_return_stack_in;
            state_d = EID_ST_NOP;
          end else begin
            ptr_d[fld] = ptr_step(ptr_q[fld], lit6, is_ptradd);
          end
        end else if (is_push_literal_op) begin
          mem_out.req = 1'b1;
          mem_out.we = 1'b1;
          mem_out.addr = ptr_q[2];
          mem_out.wdata = lit8;
          ptr_d[2] = ptr_q[2] - 12'h001;
        end else if (is_call_via_accumulator_op) begin
          stack_out.push = 1'b1;
          stack_out.data = pc_in + `EID_PC_STEP;
          pc_load_out = 1'b1;
          pc_value_out = {program_counter_upper_latch_in[4:0],
            program_counter_high_latch_in, acc_q};
          state_d = EID_ST_NOP;
        end else if (is_move1) begin
          mem_out.req = 1'b1;
          mem_out.addr = mv_src_addr;
          state_d = EID_ST_MOVE2;
        end else if (is_accumulate_to_file_op) begin
          mem_out.req = 1'b1;
          mem_out.addr = ax_addr;
          flags_we_out = 1'b1;
          if (insn_in[9]) begin
            mem_out.we = 1'b1;
            mem_out.wdata = sum[7:0];
          end else begin
            acc_d = sum[7:0];
          end
        end
      end
      EID_ST_NOP: begin
        if (insn_valid_in) begin
          state_d = EID_ST_RUN;
        end
      end
      EID_ST_MOVE2: begin
        if (move_second) begin
          mem_out.req = 1'b1;
          mem_out.we = 1'b1;
          mem_out.addr = mv_dst_addr;
          mem_out.wdata = mv_data_q;
          state_d = EID_ST_RUN;
        end
      end
      default: begin
        state_d = EID_ST_RUN;
      end
    endcase
  end
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      state_q <= EID_ST_RUN;
      acc_q <= `EID_ACC_RESET;
      mv_data_q <= '0;
      for (int i = 0; i < 3; i++) begin
        ptr_q[i] <= `EID_PTR_RESET;
      end
    end else begin
      state_q <= state_d;
      acc_q <= acc_d;
      if (is_move1) begin
        mv_data_q <= mem_rdata_in;
      end
      for (int i = 0; i < 3; i++) begin
        ptr_q[i] <= ptr_d[i];
      end
    end
  end
  assign busy_out = state_q != EID_ST_RUN;
  assign accumulator_register_out = acc_q;
  assign indirect_pointer_zero_out = ptr_q[0];
  assign indirect_pointer_one_out = ptr_q[1];
  assign indirect_pointer_two_out = ptr_q[2];
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_disabled_quiet;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (!en && insn_valid_in && insn_in[15:8] == `EID_OP_PUSH_LITERAL_OP) |-> !mem_out.we;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet)
    else $error("extended opcode ran while disabled");
  property p_index_addr;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (is_accumulate_to_file_op && en && !insn_in[8] && insn_in[7:0] <= `EID_OFFSET_MAX) |->
      mem_out.addr == ptr_q[2] + {4'h0, insn_in[7:0]};
  endproperty
  a_index_addr: assert property (p_index_addr)
    else $error("indexed address wrong");
  property p_bank_addr;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (is_accumulate_to_file_op && insn_in[8]) |->
      mem_out.addr == {bank_select_register_in, insn_in[7:0]};
  endproperty
  a_bank_addr: assert property (p_bank_addr)
    else $error("banked address wrong");
  property p_dest_acc;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (is_accumulate_to_file_op && !insn_in[9]) |=> acc_q == $past(sum[7:0]);
  endproperty
  a_dest_acc: assert property (p_dest_acc)
    else $error("sum not in accumulator");
  sequence s_ret_first;
    is_ret && (is_ptradd || is_ptrsub);
  endsequence
  property p_ret_two;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    s_ret_first |-> pc_load_out ##1 busy_out;
  endproperty
  a_ret_two: assert property (p_ret_two)
    else $error("return form not two cycles");
  property p_ret_ptr;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    s_ret_first |=> $stable(ptr_q[0]) && $stable(ptr_q[1]);
  endproperty
  a_ret_ptr: assert property (p_ret_ptr)
    else $error("return form touched another pointer");
  property p_push_dec;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    is_push_literal_op |=> ptr_q[2] == $past(ptr_q[2]) - 12'h001;
  endproperty
  a_push_dec: assert property (p_push_dec)
    else $error("push did not decrement pointer two");
  property p_call_via_accumulator_op;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    is_call_via_accumulator_op |-> stack_out.push && stack_out.data == pc_in + `EID_PC_STEP;
  endproperty
  a_call_via_accumulator_op: assert property (p_call_via_accumulator_op)
    else $error("call did not push next address");
  property p_call_via_accumulator_op_two;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    is_call_via_accumulator_op |=> busy_out;
  endproperty
  a_call_via_accumulator_op_two: assert property (p_call_via_accumulator_op_two)
    else $error("call did not take a second cycle");
  property p_ret_pc;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    s_ret_first |-> stack_out.pop && pc_value_out == top_of_return_stack_in;
  endproperty
  a_ret_pc: assert property (p_ret_pc)
    else $error("return form did not load top of stack");
  // the flushed word must leave no trace outside
  property p_nop_quiet;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (state_q == EID_ST_NOP) |->
      !mem_out.req && !stack_out.push && !stack_out.pop && !pc_load_out;
  endproperty
  a_nop_quiet: assert property (p_nop_quiet)
    else $error("second cycle was not a no-operation");
  property p_no_flags;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (is_ptradd || is_ptrsub || is_push_literal_op || is_call_via_accumulator_op) |-> !flags_we_out;
  endproperty
  a_no_flags: assert property (p_no_flags)
    else $error("extended opcode touched status flags");
  property p_push_store;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    is_push_literal_op |-> mem_out.we && mem_out.addr == ptr_q[2] &&
      mem_out.wdata == lit8;
  endproperty
  a_push_store: assert property (p_push_store)
    else $error("push literal stored wrong");
  property p_keep_acc;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (is_accumulate_to_file_op && insn_in[9]) |=> $stable(acc_q);
  endproperty
  a_keep_acc: assert property (p_keep_acc)
    else $error("file destination changed the accumulator");
  property p_literal_addr;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (is_accumulate_to_file_op && !en && !insn_in[8] &&
      insn_in[7:0] < `EID_ACCESS_SPLIT) |->
      mem_out.addr == {4'h0, insn_in[7:0]};
  endproperty
  a_literal_addr: assert property (p_literal_addr)
    else $error("disabled access bank address wrong");
  // data read by the first word lands at the second word's address
  sequence s_move_first;
    is_move1;
  endsequence
  sequence s_move_second;
    move_second;
  endsequence
  property p_move_copy;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    s_move_first ##1 s_move_second |->
      mem_out.we && mem_out.wdata == $past(mem_rdata_in) &&
      mem_out.addr == ptr_q[2] + {5'h00, insn_in[6:0]};
  endproperty
  a_move_copy: assert property (p_move_copy)
    else $error("indexed move copied wrong");
endmodule // eid_decode

// file: bench/extended_insn_indexed_decode_test.sv
// self-checking bench for the extended decode block
`timescale 1ns/10ps
module extended_insn_indexed_decode_test
  import eid_pkg::*;
;
  typedef struct packed {
    logic cfg;
    logic [15:0] insn;
    logic [11:0] addr;
  } eid_row_t;
  logic ref_clk_in, rst_n_in, cfg_in, insn_valid_in;
  logic [15:0] insn_in;
  logic [20:0] pc_in, tos_in, pc_value_out;
  logic [7:0] mem_rdata_in, high_in, upper_in, acc_out;
  logic [3:0] bank_in;
  eid_mem_t mem_out;
  eid_stack_t stack_out;
  logic pc_load_out, busy_out, flags_we_out;
  logic [11:0] ptr0_out, ptr1_out, ptr2_out;
  int mismatches = 0;
  int check_count = 0;
  // d=1 forms keep the accumulator still; pointer two is 020h here
  eid_row_t rows [7] = '{
    '{1'b0, 16'h2605, 12'h005}, '{1'b0, 16'h2680, 12'hf80},
    '{1'b0, 16'h2705, 12'h305}, '{1'b1, 16'h2605, 12'h025},
    '{1'b1, 16'h265f, 12'h07f}, '{1'b1, 16'h2660, 12'hf60},
    '{1'b1, 16'h2705, 12'h305}};
  eid_decode u_eid_decode (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .extended_set_config_bit_in(cfg_in), .insn_valid_in(insn_valid_in),
    .insn_in(insn_in), .pc_in(pc_in), .mem_rdata_in(mem_rdata_in),
    .top_of_return_stack_in(tos_in),
    .program_counter_high_latch_in(high_in),
    .program_counter_upper_latch_in(upper_in),
    .bank_select_register_in(bank_in), .mem_out(mem_out),
    .stack_out(stack_out), .pc_load_out(pc_load_out),
    .pc_value_out(pc_value_out), .busy_out(busy_out),
    .flags_we_out(flags_we_out), .accumulator_register_out(acc_out),
    .indirect_pointer_zero_out(ptr0_out),
    .indirect_pointer_one_out(ptr1_out),
    .indirect_pointer_two_out(ptr2_out));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // drive 1 ns after the edge, look at pulses 5 ns later
  task automatic step(input logic c, input logic v, input logic [15:0] w);
    @(posedge ref_clk_in);
    #1;
    cfg_in = c;
    insn_valid_in = v;
    insn_in = w;
    #5;
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    ref_clk_in = 1'b0;
    forever #10 ref_clk_in = ~ref_clk_in;
  end
  // a hang costs a mismatch, not a silent run
  initial begin
    #200000;
    mismatches++;
    print_verdict();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst_n_in = 1'b0; cfg_in = 1'b0; insn_valid_in = 1'b0;
    insn_in = 16'h0000; pc_in = 21'h001000; mem_rdata_in = 8'h10;
    tos_in = 21'h0abcde; high_in = 8'h23; upper_in = 8'h01;
    bank_in = 4'h3;
    repeat (10) @(posedge ref_clk_in);
    #1;
    rst_n_in = 1'b1;
    check("busy", busy_out, 0);
    check("acc", acc_out, 0);
    step(0, 1, 16'he8a0);
    step(0, 1, 16'he8c5);
    check("pc_load", pc_load_out, 0);
    check("pop", stack_out.pop, 0);
    step(0, 1, 16'hea08);
    check("we", mem_out.we, 0);
    step(1, 1, 16'h2605);
    check("ptr2", ptr2_out, 12'h000);
    check("addr", mem_out.addr, 12'h005);
    step(1, 1, 16'he845);
    step(1, 1, 16'he905);
    check("flags", flags_we_out, 0);
    check("ptr1", ptr1_out, 12'h005);
    step(1, 1, 16'he8a0);
    check("ptr0", ptr0_out, 12'hffb);
    for (int i = 0; i < 7; i++) begin
      step(rows[i].cfg, 1, rows[i].insn);
      check("req", mem_out.req, 1);
      check("addr", mem_out.addr, rows[i].addr);
    end
    step(1, 0, 16'h0000);
    check("ptr2", ptr2_out, 12'h020);
    check("acc", acc_out, 0);
    step(1, 1, 16'h2405);
    check("flags", flags_we_out, 1);
    check("addr", mem_out.addr, 12'h025);
    step(1, 1, 16'hea08);
    check("acc", acc_out, 8'h10);
    check("we", mem_out.we, 1);
    check("addr", mem_out.addr, 12'h020);
    check("wdata", mem_out.wdata, 8'h08);
    check("flags", flags_we_out, 0);
    step(1, 1, 16'he9c5);
    check("ptr2", ptr2_out, 12'h01f);
    check("pop", stack_out.pop, 1);
    check("pc_load", pc_load_out, 1);
    check("pc", pc_value_out, 21'h0abcde);
    // second cycle word must be flushed, not run
    step(1, 1, 16'he8a0);
    check("busy", busy_out, 1);
    check("ptr2", ptr2_out, 12'h01a);
    check("ptr0", ptr0_out, 12'hffb);
    check("ptr1", ptr1_out, 12'h005);
    step(1, 1, 16'he8c5);
    check("busy", busy_out, 0);
    check("ptr2", ptr2_out, 12'h01a);
    check("pop", stack_out.pop, 1);
    // the nop cycle needs a valid word to swallow
    step(1, 1, 16'he8a0);
    check("busy", busy_out, 1);
    check("ptr2", ptr2_out, 12'h01f);
    step(1, 1, 16'h0014);
    check("push", stack_out.push, 1);
    check("push_data", stack_out.data, 21'h001002);
    check("pc_load", pc_load_out, 1);
    check("pc", pc_value_out, 21'h012310);
    step(1, 1, 16'he8a0);
    check("busy", busy_out, 1);
    mem_rdata_in = 8'h33;
    step(1, 1, 16'heb85);
    check("we", mem_out.we, 0);
    check("addr", mem_out.addr, 12'h024);
    step(1, 1, 16'hf086);
    mem_rdata_in = 8'h55;
    #1;
    check("busy", busy_out, 1);
    check("we", mem_out.we, 1);
    check("addr", mem_out.addr, 12'h025);
    check("wdata", mem_out.wdata, 8'h33);
    check("flags", flags_we_out, 0);
    step(1, 0, 16'h0000);
    check("busy", busy_out, 0);
    // reset while a return form sits in its second cycle
    step(1, 1, 16'he8c5);
    check("busy", busy_out, 0);
    @(posedge ref_clk_in);
    #1;
    rst_n_in = 1'b0;
    insn_valid_in = 1'b0;
    check("busy", busy_out, 1);
    check("ptr2", ptr2_out, 12'h024);
    @(posedge ref_clk_in);
    #1;
    rst_n_in = 1'b1;
    #5;
    check("busy", busy_out, 0);
    check("ptr2", ptr2_out, 12'h000);
    check("ptr0", ptr0_out, 12'h000);
    check("acc", acc_out, 0);
    step(1, 1, 16'hea08);
    check("addr", mem_out.addr, 12'h000);
    step(1, 0, 16'h0000);
    check("ptr2", ptr2_out, 12'hfff);
    print_verdict();
  end
endmodule // extended_insn_indexed_decode_test
